//--- hdl/mfsc_regs.vh
`ifndef MFSC_REGS_VH
`define MFSC_REGS_VH

// ==========================================================================
// Register byte offsets
`define MFSC_ADR_CTRL        8'h00
`define MFSC_ADR_PULSE_FREQ  8'h04
`define MFSC_ADR_EN_DELAY    8'h08
`define MFSC_ADR_VOUT_FILT   8'h0c
`define MFSC_ADR_SERVO_FILT  8'h10
`define MFSC_ADR_SERVO_GAIN  8'h14
`define MFSC_ADR_SERVO_SPEED 8'h18
`define MFSC_ADR_SERVO_DELAY 8'h1c
`define MFSC_ADR_STATUS      8'h20
`define MFSC_ADR_SETPOINT    8'h24
`define MFSC_ADR_FLOW        8'h28

// ==========================================================================
// Control fields
`define MFSC_CTRL_SERVO_EN   0
`define MFSC_CTRL_HOLD_EN    1
`define MFSC_CTRL_RST        2'h1

// ==========================================================================
// Status fields
`define MFSC_ST_FLOW         0
`define MFSC_ST_HOLD         1
`define MFSC_ST_SERVO_RUN    2
`define MFSC_ST_DELAYING     3
`define MFSC_ST_DUTY_LSB     16

// ==========================================================================
// Setting limits and reset values
`define MFSC_FREQ_MIN        6'h06
`define MFSC_FREQ_MAX        6'h32
`define MFSC_FREQ_RST        6'h14
`define MFSC_DLY_MIN         6'h00
`define MFSC_DLY_MAX         6'h32
`define MFSC_DLY_RST         6'h00
`define MFSC_VOUT_MIN        10'h001
`define MFSC_VOUT_MAX        10'h200
`define MFSC_VOUT_RST        10'h004
`define MFSC_SFILT_MIN       6'h01
`define MFSC_SFILT_MAX       6'h20
`define MFSC_SFILT_RST       6'h04
`define MFSC_GAIN_MIN        7'h01
`define MFSC_GAIN_MAX        7'h64
`define MFSC_GAIN_RST        7'h19
`define MFSC_SPEED_RST       7'h1e
`define MFSC_SDLY_RST        7'h1e

// ==========================================================================
// Timing
`define MFSC_CLK_PERIOD_NS   4
`define MFSC_CLK_HZ          (1000000000 / `MFSC_CLK_PERIOD_NS)
`define MFSC_DLY_STEP_MS     100
`define MFSC_DLY_STEP_CYC    ((`MFSC_DLY_STEP_MS * 1000000) / `MFSC_CLK_PERIOD_NS)

// ==========================================================================
// Data path
`define MFSC_FULL_SCALE      12'hfff
`define MFSC_P_SHIFT         4
`define MFSC_I_SHIFT         8
`define MFSC_I_LIMIT         24'h3fffff

`endif

//--- hdl/mfsc_mavg.v
`default_nettype none

// ==========================================================================
// Moving average over the last len samples, one sample per tick
module mfsc_mavg #(
  parameter MAXN = 512,
  parameter AW   = 9,
  parameter LW   = 10,
  parameter DW   = 12
) (
  input  wire          clock,
  input  wire          reset_n,
  input  wire          tick,
  input  wire [LW-1:0] len,
  input  wire [DW-1:0] din,
  output reg  [DW-1:0] dout
);

  localparam SW = DW + AW + 1;

  reg  [DW-1:0] mem [0:MAXN-1];
  reg  [AW-1:0] wr_r;
  reg  [LW-1:0] fill_r;
  reg  [LW-1:0] len_q_r;
  reg  [SW-1:0] sum_r;
  wire [AW-1:0] rd_idx;
  wire          full;
  wire [DW-1:0] old_val;
  wire [SW-1:0] sum_nxt;
  wire [SW-1:0] quot;
  wire          restart;

  assign restart = (len != len_q_r);
  assign rd_idx  = wr_r - len[AW-1:0];
  assign full    = (fill_r >= len);
  assign old_val = full ? mem[rd_idx] : {DW{1'b0}};
  assign sum_nxt = sum_r + {{(SW-DW){1'b0}}, din}
                 - {{(SW-DW){1'b0}}, old_val};
  assign quot    = sum_nxt / {{(SW-LW){1'b0}}, len};

  always @(posedge clock) begin
    if (tick) begin
      mem[wr_r] <= din;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_r    <= {AW{1'b0}};
      fill_r  <= {LW{1'b0}};
      len_q_r <= {{(LW-1){1'b0}}, 1'b1};
      sum_r   <= {SW{1'b0}};
      dout    <= {DW{1'b0}};
    end else if (restart) begin
      // New length: refill the window from empty
      len_q_r <= len;
      fill_r  <= {LW{1'b0}};
      sum_r   <= {SW{1'b0}};
    end else if (tick) begin
      wr_r  <= wr_r + {{(AW-1){1'b0}}, 1'b1};
      sum_r <= sum_nxt;
      dout  <= quot[DW-1:0];
      if (!full) begin
        fill_r <= fill_r + {{(LW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // mfsc_mavg

`default_nettype wire

//--- hdl/mfsc_core.v
`include "mfsc_regs.vh"
`default_nettype none

// Notes on behaviour
// - Pulse frequency 6 to 50 Hz, shuttle pulsed
// - Hold latches setpoint at enable rise
// - Hold indicator driven while hold enabled
// - Flow starts after enable delay elapses
// - Flow stops at once when enable drops
// - Enable delay resets 0, range 0-5 s
// - Output moving average, servo unaffected
// - Output average length default 4, 1-512
// - Output updated once per pulse period
// - Servo closed loop on sensor, default on
// - Sensor average default 4, range 1-32
// - Proportional gain 1-100, default 25
// - Integral speed 1-100, default 30
// - Servo hold-off 1-100 periods, default 30
// - Servo off: duty follows setpoint directly
// - Full-scale setpoint maps to 0-100% duty
module mfsc_core #(
  parameter CLK_HZ         = `MFSC_CLK_HZ,
  parameter DLY_STEP_CYC   = `MFSC_DLY_STEP_CYC
) (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [11:0] setpoint_in,
  input  wire        enable_in,
  input  wire [11:0] sensor_in,
  output reg         shuttle_pulse,
  output wire [11:0] analog_out,
  output reg         setpoint_hold_indicator,
  output reg         flow_active
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_DELAY = 2'd1;
  localparam ST_RUN   = 2'd2;

  // ========================================================================
  // Helpers
  function in_rng;
    input [9:0] v;
    input [9:0] lo;
    input [9:0] hi;
    begin
      in_rng = (v >= lo) && (v <= hi);
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    begin
      merge16[7:0]  = sel[0] ? dat[7:0]  : old[7:0];
      merge16[15:8] = sel[1] ? dat[15:8] : old[15:8];
    end
  endfunction

  // ========================================================================
  // Settings
  reg  [1:0]  ctrl_r;
  reg  [5:0]  freq_r;
  reg  [5:0]  dly_r;
  reg  [9:0]  vout_len_r;
  reg  [5:0]  sfilt_len_r;
  reg  [6:0]  gain_r;
  reg  [6:0]  speed_r;
  reg  [6:0]  sdly_r;

  // Bus request
  wire        req;
  wire        wr_req;
  wire [15:0] wv;

  // Sequencer
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg         en_d_r;
  reg  [31:0] dly_cnt_r;
  wire        en_rise;
  wire [31:0] dly_total;

  // Pulse timing
  reg  [31:0] pcnt_r;
  wire [31:0] period_w;
  wire [43:0] on_prod;
  wire [43:0] on_w;
  wire        tick;

  // Setpoint and servo
  reg  [11:0] sp_hold_r;
  reg  [11:0] duty_r;
  reg  [11:0] duty_nxt;
  reg  [6:0]  hold_cnt_r;
  reg  signed [23:0] integ_r;
  reg  signed [23:0] integ_nxt;
  wire [11:0] sp_act;
  wire [11:0] sens_filt;
  wire        servo_run;
  wire signed [12:0] err;
  wire signed [20:0] p_term;
  wire signed [20:0] i_step;
  wire signed [24:0] i_sum;
  wire signed [25:0] u;

  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req  = req && wb_we_i;
  assign wv      = merge16(16'h0000, wb_dat_i, wb_sel_i);

  // ========================================================================
  // Register writes; values out of range in bits 9:0 are refused (bits 15:10 checked for vout_len_r only)
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r      <= `MFSC_CTRL_RST;
      freq_r      <= `MFSC_FREQ_RST;
      dly_r       <= `MFSC_DLY_RST;
      vout_len_r  <= `MFSC_VOUT_RST;
      sfilt_len_r <= `MFSC_SFILT_RST;
      gain_r      <= `MFSC_GAIN_RST;
      speed_r     <= `MFSC_SPEED_RST;
      sdly_r      <= `MFSC_SDLY_RST;
    end else if (wr_req) begin
      case (wb_adr_i)
        `MFSC_ADR_CTRL: begin
          if (wb_sel_i[0]) begin
            ctrl_r <= wb_dat_i[1:0];
          end
        end
        `MFSC_ADR_PULSE_FREQ: begin
          if (in_rng(wv[9:0], {4'h0, `MFSC_FREQ_MIN},
                     {4'h0, `MFSC_FREQ_MAX})) begin
            freq_r <= wv[5:0];
          end
        end
        `MFSC_ADR_EN_DELAY: begin
          if (in_rng(wv[9:0], {4'h0, `MFSC_DLY_MIN},
                     {4'h0, `MFSC_DLY_MAX})) begin
            dly_r <= wv[5:0];
          end
        end
        `MFSC_ADR_VOUT_FILT: begin
          if (wv[15:10] == 6'h00 &&
              in_rng(wv[9:0], `MFSC_VOUT_MIN, `MFSC_VOUT_MAX)) begin
            vout_len_r <= wv[9:0];
          end
        end
        `MFSC_ADR_SERVO_FILT: begin
          if (in_rng(wv[9:0], {4'h0, `MFSC_SFILT_MIN},
                     {4'h0, `MFSC_SFILT_MAX})) begin
            sfilt_len_r <= wv[5:0];
          end
        end
        `MFSC_ADR_SERVO_GAIN: begin
          if (in_rng(wv[9:0], {3'h0, `MFSC_GAIN_MIN},
                     {3'h0, `MFSC_GAIN_MAX})) begin
            gain_r <= wv[6:0];
          end
        end
        `MFSC_ADR_SERVO_SPEED: begin
          if (in_rng(wv[9:0], {3'h0, `MFSC_GAIN_MIN},
                     {3'h0, `MFSC_GAIN_MAX})) begin
            speed_r <= wv[6:0];
          end
        end
        `MFSC_ADR_SERVO_DELAY: begin
          if (in_rng(wv[9:0], {3'h0, `MFSC_GAIN_MIN},
                     {3'h0, `MFSC_GAIN_MAX})) begin
            sdly_r <= wv[6:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // Bus answer, one cycle after the request
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          `MFSC_ADR_CTRL:        wb_dat_o <= {30'h0, ctrl_r};
          `MFSC_ADR_PULSE_FREQ:  wb_dat_o <= {26'h0, freq_r};
          `MFSC_ADR_EN_DELAY:    wb_dat_o <= {26'h0, dly_r};
          `MFSC_ADR_VOUT_FILT:   wb_dat_o <= {22'h0, vout_len_r};
          `MFSC_ADR_SERVO_FILT:  wb_dat_o <= {26'h0, sfilt_len_r};
          `MFSC_ADR_SERVO_GAIN:  wb_dat_o <= {25'h0, gain_r};
          `MFSC_ADR_SERVO_SPEED: wb_dat_o <= {25'h0, speed_r};
          `MFSC_ADR_SERVO_DELAY: wb_dat_o <= {25'h0, sdly_r};
          `MFSC_ADR_STATUS:      wb_dat_o <= {4'h0, duty_r, 12'h0,
                                              state_r == ST_DELAY,
                                              servo_run,
                                              ctrl_r[`MFSC_CTRL_HOLD_EN],
                                              flow_active};
          `MFSC_ADR_SETPOINT:    wb_dat_o <= {20'h0, sp_act};
          `MFSC_ADR_FLOW:        wb_dat_o <= {20'h0, sens_filt};
          default:               wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ========================================================================
  // Enable sequencer
  assign en_rise   = enable_in && !en_d_r;
  assign dly_total = {26'h0, dly_r} * DLY_STEP_CYC;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (en_rise) begin
          state_nxt = (dly_r == 6'h00) ? ST_RUN : ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!enable_in) begin
          state_nxt = ST_IDLE;
        end else if (dly_cnt_r >= dly_total - 32'd1) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enable_in) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= ST_IDLE;
      en_d_r    <= 1'b0;
      dly_cnt_r <= 32'h00000000;
      sp_hold_r <= 12'h000;
      flow_active             <= 1'b0;
      setpoint_hold_indicator <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      en_d_r    <= enable_in;
      dly_cnt_r <= (state_r == ST_DELAY) ? dly_cnt_r + 32'd1
                                         : 32'h00000000;
      if (en_rise) begin
        sp_hold_r <= setpoint_in;
      end
      flow_active <= (state_nxt == ST_RUN);
      setpoint_hold_indicator <= ctrl_r[`MFSC_CTRL_HOLD_EN];
    end
  end

  // ========================================================================
  // Pulse period and shuttle drive
  assign period_w = CLK_HZ / {26'h0, freq_r};
  assign tick     = (pcnt_r >= period_w - 32'd1);
  assign on_prod  = {12'h0, period_w} * {32'h0, duty_r};
  assign on_w     = on_prod / {32'h0, `MFSC_FULL_SCALE};

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pcnt_r        <= 32'h00000000;
      shuttle_pulse <= 1'b0;
    end else begin
      pcnt_r <= tick ? 32'h00000000 : pcnt_r + 32'd1;
      // Ends in the cycle enable falls
      shuttle_pulse <= (state_nxt == ST_RUN) &&
                       ({12'h0, pcnt_r} < on_w);
    end
  end

  // ========================================================================
  // Filters: sensor for the servo, output for the analog port
  mfsc_mavg #(
    .MAXN (32),
    .AW   (5),
    .LW   (6),
    .DW   (12)
  ) u_sens_avg (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (tick),
    .len     (sfilt_len_r),
    .din     (sensor_in),
    .dout    (sens_filt)
  );

  // Fed from the raw sensor so the servo never sees this filter
  mfsc_mavg #(
    .MAXN (512),
    .AW   (9),
    .LW   (10),
    .DW   (12)
  ) u_vout_avg (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (tick),
    .len     (vout_len_r),
    .din     (sensor_in),
    .dout    (analog_out)
  );

  // ========================================================================
  // PI servo
  assign sp_act    = ctrl_r[`MFSC_CTRL_HOLD_EN] ? sp_hold_r
                                                : setpoint_in;
  assign servo_run = ctrl_r[`MFSC_CTRL_SERVO_EN] &&
                     (state_r == ST_RUN) && (hold_cnt_r == 7'h00);
  assign err       = $signed({1'b0, sp_act}) - $signed({1'b0, sens_filt});
  assign p_term    = err * $signed({1'b0, gain_r});
  assign i_step    = err * $signed({1'b0, speed_r});
  assign i_sum     = integ_r + i_step;
  assign u         = $signed({14'h0, sp_act})
                   + (p_term >>> `MFSC_P_SHIFT)
                   + (integ_r >>> `MFSC_I_SHIFT);

  always @* begin
    integ_nxt = integ_r;
    duty_nxt  = sp_act;
    if (servo_run) begin
      if (i_sum > $signed({1'b0, `MFSC_I_LIMIT})) begin
        integ_nxt = $signed(`MFSC_I_LIMIT);
      end else if (i_sum < -$signed({1'b0, `MFSC_I_LIMIT})) begin
        integ_nxt = -$signed(`MFSC_I_LIMIT);
      end else begin
        integ_nxt = i_sum[23:0];
      end
      if (u < 26'sd0) begin
        duty_nxt = 12'h000;
      end else if (u > $signed({14'h0, `MFSC_FULL_SCALE})) begin
        duty_nxt = `MFSC_FULL_SCALE;
      end else begin
        duty_nxt = u[11:0];
      end
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt_r <= `MFSC_SDLY_RST;
      integ_r    <= 24'sd0;
      duty_r     <= 12'h000;
    end else begin
      if (state_r != ST_RUN) begin
        hold_cnt_r <= sdly_r;
        integ_r    <= 24'sd0;
      end else if (tick && hold_cnt_r != 7'h00) begin
        hold_cnt_r <= hold_cnt_r - 7'd1;
      end else if (tick) begin
        integ_r <= integ_nxt;
      end
      if (tick) begin
        duty_r <= duty_nxt;
      end
    end
  end

endmodule // mfsc_core

`default_nettype wire

//--- testbench/mfsc_asserts.sv
`default_nettype none

// ==========================================================================
// Port checks for the flow servo core
module mfsc_asserts #(
  parameter CLK_HZ = 2000
) (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [11:0] setpoint_in,
  input wire logic        enable_in,
  input wire logic [11:0] sensor_in,
  input wire logic        shuttle_pulse,
  input wire logic [11:0] analog_out,
  input wire logic        setpoint_hold_indicator,
  input wire logic        flow_active
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_ack_follows_req: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus request not acknowledged in one cycle");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("acknowledge without a request");
  a_flow_stops_now: assert property (!enable_in |=> !flow_active)
    else $error("flow still active after enable removed");
  a_pulse_stops_now: assert property (!enable_in |=> !shuttle_pulse)
    else $error("shuttle still pulsed after enable removed");
  a_pulse_in_flow: assert property (shuttle_pulse |-> flow_active)
    else $error("shuttle pulsed while flow inactive");
  a_flow_after_enable: assert property (
    $rose(flow_active) |-> $past(enable_in))
    else $error("flow started without enable held");
  a_aout_per_period: assert property (
    $changed(analog_out) |=> $stable(analog_out) [*8])
    else $error("analog output updated faster than the pulse period");
  a_hold_after_write: assert property (
    $changed(setpoint_hold_indicator) |-> $past(wb_ack_o && wb_we_i))
    else $error("hold indicator changed without a register write");
endmodule // mfsc_asserts

`default_nettype wire

//--- testbench/mfsc_plc.sv
`default_nettype none

// ==========================================================================
// Controller model driving setpoint, enable and the flow sensor
module mfsc_plc (
  input  wire logic   clock,
  output logic [11:0] setpoint_in,
  output logic        enable_in,
  output logic [11:0] sensor_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    setpoint_in = 12'h000;
    enable_in = 1'b0;
    sensor_in = 12'h000;
  end

  task automatic run(input logic [11:0] sp);
    @(posedge clock);
    setpoint_in <= sp;
    enable_in <= 1'b1;
  endtask

  // Enable stays low a full cycle so the next run is a new cycle
  task automatic stop();
    @(posedge clock);
    enable_in <= 1'b0;
    @(posedge clock);
  endtask

  task automatic set_sp(input logic [11:0] sp);
    @(posedge clock);
    setpoint_in <= sp;
  endtask

  task automatic set_sensor(input logic [11:0] s);
    @(posedge clock);
    sensor_in <= s;
  endtask
endmodule // mfsc_plc

`default_nettype wire

//--- testbench/tb.sv
`include "mfsc_regs.vh"
`default_nettype none

`define CHK(a, b) begin \
  num_checks++; \
  if ((a) !== (b)) begin \
    err_total++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); \
  end \
end

// ==========================================================================
// Top bench
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CLK_HZ = 2000;
  localparam int STEP   = 10;

  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o;
  wire  [11:0] setpoint_in;
  wire         enable_in;
  wire  [11:0] sensor_in;
  wire         shuttle_pulse;
  wire  [11:0] analog_out;
  wire         setpoint_hold_indicator;
  wire         flow_active;
  int          err_total = 0;
  int          num_checks = 0;
  int          cyc_cnt = 0;
  logic [15:0] mdl [8];
  logic [31:0] q;

  always #2 clock = ~clock;

  mfsc_core #(.CLK_HZ(CLK_HZ), .DLY_STEP_CYC(STEP)) u_dut (
    .clock, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .setpoint_in, .enable_in, .sensor_in,
    .shuttle_pulse, .analog_out, .setpoint_hold_indicator, .flow_active
  );

  mfsc_plc u_plc (.clock, .setpoint_in, .enable_in, .sensor_in);

  // ========================================================================
  // Expectation helpers
  function automatic logic [15:0] lim(input int i, input bit hi);
    case (i)
      1: return hi ? 16'(`MFSC_FREQ_MAX) : 16'(`MFSC_FREQ_MIN);
      2: return hi ? 16'(`MFSC_DLY_MAX) : 16'(`MFSC_DLY_MIN);
      3: return hi ? 16'(`MFSC_VOUT_MAX) : 16'(`MFSC_VOUT_MIN);
      4: return hi ? 16'(`MFSC_SFILT_MAX) : 16'(`MFSC_SFILT_MIN);
      default: return hi ? 16'(`MFSC_GAIN_MAX) : 16'(`MFSC_GAIN_MIN);
    endcase
  endfunction

  function automatic logic [15:0] rstv(input int i);
    logic [15:0] t [8];
    t = '{16'h1, 16'd20, 16'd0, 16'd4, 16'd4, 16'd25, 16'd30, 16'd30};
    return t[i];
  endfunction

  function automatic logic [15:0] keep(input int i, input logic [15:0] v);
    return (v >= lim(i, 0) && v <= lim(i, 1)) ? v : mdl[i];
  endfunction

  function automatic int exp_high(input int freq, input logic [11:0] sp);
    return (CLK_HZ / freq) * int'(sp) / 4095;
  endfunction

  // ========================================================================
  // Bus and timing tasks
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask

  task automatic per(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic count_high(input int c, output int n);
    n = 0;
    repeat (c) begin
      @(posedge clock);
      if (shuttle_pulse === 1'b1) n++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  // ========================================================================
  // Main sequence
  initial begin
    int i;
    int k;
    int n;
    logic [15:0] v;
    logic [11:0] s;
    logic [11:0] sv;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    void'($urandom(32'h0750));
    for (i = 0; i < 8; i++) begin
      mdl[i] = rstv(i);
      rd(8'(i * 4));
      `CHK(q[15:0], mdl[i])
    end
    rd(8'h3c);
    `CHK(q, 32'h0)
    // Limits on both sides, then random values
    for (i = 1; i < 8; i++) begin
      for (k = 0; k < 6; k++) begin
        case (k)
          0: v = lim(i, 0) - 16'h1;
          1: v = lim(i, 0);
          2: v = lim(i, 1);
          3: v = lim(i, 1) + 16'h1;
          default: v = 16'($urandom_range(600, 0));
        endcase
        wr(8'(i * 4), {16'h0, v});
        mdl[i] = keep(i, v);
        rd(8'(i * 4));
        `CHK(q[15:0], mdl[i])
      end
    end
    // Latched setpoint, open loop
    wr(`MFSC_ADR_PULSE_FREQ, 32'd20);
    wr(`MFSC_ADR_EN_DELAY, 32'd0);
    wr(`MFSC_ADR_VOUT_FILT, 32'd4);
    wr(`MFSC_ADR_SERVO_FILT, 32'd4);
    wr(`MFSC_ADR_CTRL, 32'h2);
    per(2);
    `CHK(setpoint_hold_indicator, 1'b1)
    s = 12'($urandom_range(4095, 1));
    sv = 12'($urandom);
    u_plc.set_sensor(sv);
    u_plc.run(s);
    per(2);
    `CHK(flow_active, 1'b1)
    u_plc.set_sp(~s);
    rd(`MFSC_ADR_SETPOINT);
    `CHK(q[11:0], s)
    per(600);
    count_high(100, n);
    `CHK(n, exp_high(20, s))
    `CHK(analog_out, sv)
    rd(`MFSC_ADR_FLOW);
    `CHK(q[11:0], sv)
    u_plc.stop();
    per(1);
    `CHK(flow_active, 1'b0)
    // Unlatched setpoint follows the input
    wr(`MFSC_ADR_CTRL, 32'h0);
    per(2);
    `CHK(setpoint_hold_indicator, 1'b0)
    u_plc.run(12'hfff);
    per(300);
    count_high(100, n);
    `CHK(n, exp_high(20, 12'hfff))
    u_plc.set_sp(12'h000);
    per(300);
    count_high(100, n);
    `CHK(n, 0)
    u_plc.stop();
    // Enable delay of three steps
    wr(`MFSC_ADR_EN_DELAY, 32'd3);
    u_plc.run(12'h800);
    per(3 * STEP - 5);
    `CHK(flow_active, 1'b0)
    rd(`MFSC_ADR_STATUS);
    `CHK(q[`MFSC_ST_DELAYING], 1'b1)
    per(10);
    `CHK(flow_active, 1'b1)
    u_plc.stop();
    wr(`MFSC_ADR_EN_DELAY, 32'd0);
    // Servo hold-off and closed loop
    wr(`MFSC_ADR_SERVO_DELAY, 32'd3);
    wr(`MFSC_ADR_PULSE_FREQ, 32'd50);
    wr(`MFSC_ADR_CTRL, 32'h1);
    u_plc.set_sensor(12'h000);
    for (k = 0; k < 2; k++) begin
      u_plc.run(12'h800);
      per(2);
      rd(`MFSC_ADR_STATUS);
      `CHK(q[`MFSC_ST_SERVO_RUN], 1'b0)
      per(40 * 6);
      rd(`MFSC_ADR_STATUS);
      `CHK(q[`MFSC_ST_SERVO_RUN], 1'b1)
      `CHK(q[27:16] > 12'h800, 1'b1)
      u_plc.stop();
    end
    end_of_test();
  end
endmodule // tb

bind mfsc_core mfsc_asserts #(.CLK_HZ(CLK_HZ)) u_chk (
  .clock, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .setpoint_in, .enable_in, .sensor_in,
  .shuttle_pulse, .analog_out, .setpoint_hold_indicator, .flow_active
);

`default_nettype wire
